/* File: bench/tb_wdt_top.sv */
// self-checking bench for wdt_top: registers, timeouts, inactive modes
// assumes the rtl files compiled first and the monitor bound to wdt_top
`include "wdt_regs.vh"

module tb_wdt_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0]  VEC   = 8'h5a; // arbitrary vector byte
  localparam [17:0] A_CLR = {`WDT_IDX_CLEAR, 2'b00};
  localparam [17:0] A_CFG = {`WDT_IDX_CFG, 2'b00};
  localparam [17:0] A_CAU = {`WDT_IDX_CAUSE, 2'b00};
  localparam [17:0] A_BRK = {`WDT_IDX_BRK, 2'b00};
  localparam [17:0] A_STA = {`WDT_IDX_STAT, 2'b00};
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [17:0] adr = 18'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [5:0]  md = 6'h02; // stop, wait, monitor, test voltage, break, internal reset
  logic        wrq, srst, pin, pin_oe_n;
  int          n_fail = 0, compares = 0, n_rst = 0, n_pin = 0, seed = 32'h2ab49fc6;
  logic [31:0] exp_q[$];

  always #2 clk = ~clk;

  wdt_top #(.VEC_LO(VEC)) wdt_top_i (
    .core_clk_in(clk), .rst_in(rst), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wrq), .stop_mode_in(md[0]), .wait_mode_in(md[1]),
    .monitor_mode_in(md[2]), .test_entry_voltage_in(md[3]), .break_active_in(md[4]),
    .internal_reset_in(md[5]), .system_reset_out(srst), .reset_pin_out(pin),
    .reset_pin_oe_n_out(pin_oe_n));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // reads note their expectation; the watcher below compares
  task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [31:0] e);
    int k = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    if (!w) exp_q.push_back(e);
    do begin
      @(negedge clk);
      k++;
    end while (wrq !== 1'b0 && k < 50);
    if (k >= 50) n_fail++;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // ----------------------------------------
  // result watchers
  // ----------------------------------------
  always @(negedge clk) begin
    if (rd && wrq === 1'b0) chk("readdata", rdata, exp_q.pop_front());
    if (srst === 1'b1) n_rst++;
    if (pin_oe_n === 1'b0) n_pin++;
  end

  task automatic reboot(input logic [2:0] cfg);
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(1, A_CFG, {29'h0, cfg}, 0);
  endtask

  task automatic quiet(input int n);
    int r0 = n_rst;
    repeat (n) @(posedge clk);
    chk("reset count", n_rst - r0, 0);
  endtask

  // timeout must land about 2^13 cycles after the counters were zeroed
  task automatic expire;
    int r0 = n_rst, t = 0;
    while (n_rst == r0 && t < 9000) begin
      @(negedge clk);
      t++;
    end
    chk("short timeout", t >= 8170 && t <= 8200, 1);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end

  initial begin
    logic [31:0] d;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    d = $random(seed);
    bus(0, A_CLR, 0, {24'h0, VEC});
    bus(0, A_CFG, 0, 32'h4);
    bus(0, 18'h00100, 0, 0);
    bus(1, A_BRK, d, 0);
    bus(0, A_BRK, 0, {31'h0, d[0]});
    bus(1, A_CFG, 32'h7, 0);
    bus(1, A_CFG, 32'h6, 0);
    bus(0, A_CFG, 0, 32'h7);
    quiet(9000);
    bus(0, A_STA, 0, 32'h80000);
    $display("test registers and disable done");
    reboot(3'h6);
    bus(1, A_CFG, 32'h1, 0);
    repeat (2) begin
      repeat (4000) @(posedge clk);
      bus(1, A_CLR, $random(seed), 0);
    end
    @(posedge clk);
    md <= 6'h03;
    quiet(9000);
    md <= 6'h02;
    bus(1, A_CLR, $random(seed), 0);
    expire;
    bus(0, A_CAU, 0, 32'h1);
    bus(1, A_CAU, 32'h1, 0);
    bus(0, A_CAU, 0, 32'h0);
    @(posedge clk);
    md <= 6'h22;
    @(posedge clk);
    md <= 6'h02;
    expire;
    repeat (40) @(posedge clk);
    chk("pin low cycles", n_pin, 64);
    $display("test short timeout done");
    reboot(3'h6);
    bus(1, A_BRK, 32'h1, 0);
    md <= 6'h0c;
    quiet(9000);
    md <= 6'h14;
    quiet(9000);
    reboot(3'h4);
    md <= 6'h00;
    quiet(9000);
    $display("test inactive and long period done");
    tally_and_finish;
  end
endmodule // tb_wdt_top

/* File: bench/wdt_top_monitor.sv */
// checker for wdt_top: bus handshake, reset pulse, reset pin timing
// assumes one clock domain and the reset pin function left enabled
`include "wdt_regs.vh"

module wdt_top_monitor #(
  parameter [7:0] VEC_LO = 8'h00
) (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic [17:0] avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        stop_mode_in,
  input wire logic        internal_reset_in,
  input wire logic        system_reset_out,
  input wire logic        reset_pin_out,
  input wire logic        reset_pin_oe_n_out
);
  // ----------------------------------------
  // pin low time left after a pulse
  // ----------------------------------------
  logic [5:0] pin_cnt;
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
      pin_cnt <= 6'h00;
    else if (system_reset_out)
      pin_cnt <= 6'h1f;
    else if (pin_cnt != 6'h00)
      pin_cnt <= pin_cnt - 6'h01;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence bus_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence bus_done;
    (avs_read_in || avs_write_in) && !avs_waitrequest_out;
  endsequence
  sequence clr_hit;
    !avs_waitrequest_out && avs_address_in[17:2] == `WDT_IDX_CLEAR;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  one_wait_a: assert property (bus_req |=> bus_done)
    else $error("bus request not answered after one wait cycle");
  idle_ready_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest high without a request");
  vector_read_a: assert property ((avs_read_in and clr_hit) |->
    avs_readdata_out == {24'h0, VEC_LO})
    else $error("clear address read did not return vector byte");
  clear_quiet_a: assert property ((avs_write_in and clr_hit) |=>
    !system_reset_out [*8])
    else $error("reset soon after a clear write");
  pulse_once_a: assert property (system_reset_out |=> !system_reset_out)
    else $error("system reset longer than one cycle");
  pin_time_a: assert property (reset_pin_oe_n_out == !(system_reset_out || pin_cnt != 6'h00))
    else $error("reset pin low time wrong");
  pin_drive_a: assert property (reset_pin_out == 1'b0)
    else $error("reset pin driven high");
  stop_hold_a: assert property (stop_mode_in |=> !system_reset_out)
    else $error("timeout while stopped");
  irst_hold_a: assert property (internal_reset_in |=> !system_reset_out [*4])
    else $error("timeout right after internal reset");
endmodule // wdt_top_monitor

bind wdt_top wdt_top_monitor #(.VEC_LO(VEC_LO)) wdt_top_monitor_i (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .stop_mode_in(stop_mode_in),
  .internal_reset_in(internal_reset_in), .system_reset_out(system_reset_out),
  .reset_pin_out(reset_pin_out), .reset_pin_oe_n_out(reset_pin_oe_n_out));

/* File: rtl/wdt_pulse_stretch.v */
// stretches a one-cycle start pulse into a level of a fixed number of cycles
// assumes start is synchronous to clk_in; a start while busy restarts the count
module wdt_pulse_stretch #(
  parameter CYCLES = 32,
  parameter CW     = 6
) (
  input  wire clk_in,
  input  wire rst_in,
  input  wire start_in,
  output wire active_out
);

  // ----------------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------------
  reg  [CW-1:0] remain;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      remain <= {CW{1'b0}};
    end else if (start_in) begin
      remain <= CYCLES[CW-1:0];
    end else if (remain != {CW{1'b0}}) begin
      remain <= remain - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign active_out = (remain != {CW{1'b0}});

endmodule // wdt_pulse_stretch

/* File: rtl/wdt_regs.vh */
// constants for the watchdog timeout counter: offsets, fields, resets, counts
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define WDT_IDX_CLEAR     16'hffff
`define WDT_IDX_CFG       16'h0010
`define WDT_IDX_CAUSE     16'h0011
`define WDT_IDX_BRK       16'h0012
`define WDT_IDX_STAT      16'h0013

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define WDT_CFG_DIS_BIT   0
`define WDT_CFG_RATE_BIT  1
`define WDT_CFG_PIN_BIT   2
`define WDT_CAUSE_WD_BIT  0
`define WDT_BRK_DIS_BIT   0
`define WDT_STAT_WD_LSB   12
`define WDT_STAT_ACT_BIT  18
`define WDT_STAT_POR_BIT  19

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define WDT_CFG_RST       3'h4
`define WDT_BRK_RST       1'h0
`define WDT_VEC_LO_RST    8'h00

// ----------------------------------------------------------------------
// widths and timing counts, in quad bus clock cycles
// ----------------------------------------------------------------------
`define WDT_PRE_W         12
`define WDT_WD_W          6
`define WDT_POR_CYCLES    4096
`define WDT_PIN_CYCLES    32
`define WDT_SVC_KEEP      4

`endif

/* File: rtl/wdt_top.v */
// watchdog timeout counter: prescaler, watchdog counter, reset generation
// assumes core_clk_in is the quad bus clock and all inputs are synchronous
`include "wdt_regs.vh"

module wdt_top #(
  parameter [7:0] VEC_LO = `WDT_VEC_LO_RST
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  // avalon-mm slave
  input  wire [17:0] avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // device state
  input  wire        stop_mode_in,
  input  wire        wait_mode_in,
  input  wire        monitor_mode_in,
  input  wire        test_entry_voltage_in,
  input  wire        break_active_in,
  input  wire        internal_reset_in,
  // reset outputs
  output reg         system_reset_out,
  output wire        reset_pin_out,
  output wire        reset_pin_oe_n_out
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function is_idx;
    input [17:0] addr;
    input [15:0] idx;
    begin
      is_idx = (addr[17:2] == idx);
    end
  endfunction

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  // every access takes two edges: data is set up at the first, and the
  // master sees waitrequest low and completes at the second
  localparam BUS_IDLE = 1'b0;
  localparam BUS_DONE = 1'b1;

  reg         bus_state;
  reg         next_bus_state;
  wire        bus_ack;
  wire        bus_req;
  wire        bus_take;
  wire        wr_take;
  wire        hit_clear;
  wire        hit_cfg;
  wire        hit_cause;
  wire        hit_brk;
  wire        hit_stat;

  assign bus_ack             = (bus_state == BUS_DONE);
  assign bus_req             = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~bus_ack;
  assign bus_take            = bus_req & bus_ack;
  assign wr_take             = bus_take & avs_write_in;

  assign hit_clear = is_idx(avs_address_in, `WDT_IDX_CLEAR);
  assign hit_cfg   = is_idx(avs_address_in, `WDT_IDX_CFG);
  assign hit_cause = is_idx(avs_address_in, `WDT_IDX_CAUSE);
  assign hit_brk   = is_idx(avs_address_in, `WDT_IDX_BRK);
  assign hit_stat  = is_idx(avs_address_in, `WDT_IDX_STAT);

  always @* begin
    next_bus_state = BUS_IDLE;
    case (bus_state)
      BUS_IDLE: begin
        if (bus_req) begin
          next_bus_state = BUS_DONE;
        end
      end
      BUS_DONE: begin
        // one wait cycle, then back to idle whatever the master does
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // ----------------------------------------------------------------------
  // configuration, write once after each reset; break disable writable at any time
  // ----------------------------------------------------------------------
  reg  [2:0] cfg;
  reg        cfg_locked;
  reg        brk_dis;
  wire       watchdog_disable;
  wire       watchdog_rate_select;
  wire       reset_pin_enable;

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg        <= `WDT_CFG_RST;
      cfg_locked <= 1'b0;
    end else if (wr_take && hit_cfg && !cfg_locked) begin
      // later writes are ignored until the next reset, like a fuse
      cfg        <= avs_writedata_in[2:0];
      cfg_locked <= 1'b1;
    end
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      brk_dis <= `WDT_BRK_RST;
    end else if (wr_take && hit_brk) begin
      brk_dis <= avs_writedata_in[`WDT_BRK_DIS_BIT];
    end
  end

  assign watchdog_disable     = cfg[`WDT_CFG_DIS_BIT];
  assign watchdog_rate_select = cfg[`WDT_CFG_RATE_BIT];
  assign reset_pin_enable     = cfg[`WDT_CFG_PIN_BIT];

  // ----------------------------------------------------------------------
  // activity conditions
  // ----------------------------------------------------------------------
  // wait mode is deliberately not an input to any of this: the counters
  // keep running, so firmware that idles in wait must still service it
  wire monitor_off;
  wire break_off;
  wire wd_active;
  wire wait_unused;

  assign monitor_off = monitor_mode_in & test_entry_voltage_in;
  assign break_off   = monitor_mode_in & break_active_in & brk_dis;
  assign wd_active   = ~watchdog_disable & ~monitor_off & ~break_off;
  assign wait_unused = wait_mode_in;

  // ----------------------------------------------------------------------
  // power-on delay
  // ----------------------------------------------------------------------
  reg  [12:0] por_cnt;
  reg         por_done;
  wire        por_clear;

  assign por_clear = ~por_done & (por_cnt == `WDT_POR_CYCLES - 1);

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      por_cnt <= 13'h0000;
    end else if (!por_done) begin
      por_cnt <= por_cnt + 13'h0001;
    end
  end

  // the delay runs once per reset and then stays done, so the count stops
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      por_done <= 1'b0;
    end else if (por_clear) begin
      por_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // prescaler and watchdog counter
  // ----------------------------------------------------------------------
  // the prescaler ticks on every quad bus clock; there is no divider
  // because the core clock is that clock itself
  reg  [`WDT_PRE_W-1:0] pre;
  reg  [`WDT_WD_W-1:0]  wd;
  reg  [`WDT_PRE_W-1:0] next_pre;
  reg  [`WDT_WD_W-1:0]  next_wd;
  reg                   stop_q;
  wire [`WDT_PRE_W-1:0] svc_keep;
  wire                  pre_wrap;
  wire                  timeout;
  wire                  service;
  wire                  stop_entry;

  assign pre_wrap   = (pre == {`WDT_PRE_W{1'b1}});
  assign service    = wr_take & hit_clear;
  assign stop_entry = stop_mode_in & ~stop_q;

  // a clear write zeroes the upper stages only; the low stages keep
  // running, so a period after a clear is a few cycles short
  genvar g;
  generate
    for (g = 0; g < `WDT_PRE_W; g = g + 1) begin : g_keep
      assign svc_keep[g] = (g < `WDT_SVC_KEEP);
    end
  endgenerate

  // short period ends when the count crosses 2^13, long at 2^18
  wire short_end;
  wire long_end;

  assign short_end = pre_wrap & wd[0];
  assign long_end  = pre_wrap & (wd == {`WDT_WD_W{1'b1}});
  assign timeout   = wd_active & ~stop_mode_in &
                     (watchdog_rate_select ? short_end : long_end);

  always @* begin
    next_pre = pre;
    next_wd  = wd;
    if (internal_reset_in || timeout || !wd_active) begin
      next_pre = {`WDT_PRE_W{1'b0}};
      next_wd  = {`WDT_WD_W{1'b0}};
    end else if (stop_entry || stop_mode_in) begin
      next_pre = {`WDT_PRE_W{1'b0}};
    end else if (service) begin
      next_pre = pre & svc_keep;
      next_wd  = {`WDT_WD_W{1'b0}};
    end else if (por_clear) begin
      next_pre = {`WDT_PRE_W{1'b0}};
    end else begin
      next_pre = pre + {{(`WDT_PRE_W-1){1'b0}}, 1'b1};
      if (pre_wrap) begin
        next_wd = wd + {{(`WDT_WD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre <= {`WDT_PRE_W{1'b0}};
    end else begin
      pre <= next_pre;
    end
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wd <= {`WDT_WD_W{1'b0}};
    end else begin
      wd <= next_wd;
    end
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_mode_in;
    end
  end

  // ----------------------------------------------------------------------
  // reset generation and cause flag
  // ----------------------------------------------------------------------
  // the watchdog raises no interrupt; a timeout only ever resets
  reg  wd_flag;
  wire pin_active;

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      system_reset_out <= 1'b0;
    end else begin
      system_reset_out <= timeout;
    end
  end

  // set wins over a clear written in the same cycle
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wd_flag <= 1'b0;
    end else if (timeout) begin
      wd_flag <= 1'b1;
    end else if (wr_take && hit_cause && avs_writedata_in[`WDT_CAUSE_WD_BIT]) begin
      wd_flag <= 1'b0;
    end
  end

  wdt_pulse_stretch #(
    .CYCLES (`WDT_PIN_CYCLES),
    .CW     (6)
  ) u_pin_stretch (
    .clk_in     (core_clk_in),
    .rst_in     (rst_in),
    .start_in   (timeout & reset_pin_enable),
    .active_out (pin_active)
  );

  // open drain: only ever pulls low
  assign reset_pin_out      = 1'b0;
  assign reset_pin_oe_n_out = ~pin_active;

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  // reading the clear address has no side effect on the counters
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_clear) begin
      rd_mux[7:0] = VEC_LO;
    end else if (hit_cfg) begin
      rd_mux[2:0] = cfg;
    end else if (hit_cause) begin
      rd_mux[`WDT_CAUSE_WD_BIT] = wd_flag;
    end else if (hit_brk) begin
      rd_mux[`WDT_BRK_DIS_BIT] = brk_dis;
    end else if (hit_stat) begin
      rd_mux[`WDT_PRE_W-1:0]                       = pre;
      rd_mux[`WDT_STAT_WD_LSB+`WDT_WD_W-1:`WDT_STAT_WD_LSB] = wd;
      rd_mux[`WDT_STAT_ACT_BIT]                    = wd_active;
      rd_mux[`WDT_STAT_POR_BIT]                    = por_done;
    end
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !bus_ack) begin
      avs_readdata_out <= rd_mux;
    end
  end

endmodule // wdt_top
